// >>> xlate_pkg.sv
/*
 * Shared constants for the peer-to-Modbus message translator: register map,
 * field positions, reset values, protocol codes and timing counts.
 * Assumes a single 125 MHz clock and a plain strobe register port.
 */
package xlate_pkg;

   // Clock and retry timing
   localparam int CLK_PERIOD_NS  = 8;
   localparam int RETRY_UNIT_NS  = 1000;
   localparam int RETRY_UNIT_CYC = (RETRY_UNIT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   RETRY_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [1:0] MAX_RETRIES = 2'h2;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_BIAS   = 8'h04;
   localparam logic [7:0] OFS_OPCODE = 8'h08;
   localparam logic [7:0] OFS_RETRY  = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // Field positions
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_STRICT    = 2;
   localparam int OPC_RD_LSB     = 0;
   localparam int OPC_WR_LSB     = 8;
   localparam int STAT_TRIES_LSB = 0;
   localparam int STAT_BUSY      = 2;
   localparam int STAT_GAVEUP    = 3;

   // Reset values
   localparam logic [1:0]  RST_MODE   = 2'h0;
   localparam logic [15:0] RST_BIAS   = 16'h0000;
   localparam logic [7:0]  RST_RD_OP  = 8'h03;
   localparam logic [7:0]  RST_WR_OP  = 8'h10;
   localparam logic [15:0] RST_RETRY  = 16'h03E8;

   // Port modes
   localparam logic [1:0] MODE_GATE  = 2'h0;
   localparam logic [1:0] MODE_ASCII = 2'h1;
   localparam logic [1:0] MODE_HOST  = 2'h2;
   localparam logic [1:0] MODE_SLAVE = 2'h3;

   // Peer opcodes
   localparam logic [7:0] P_PRI_READ  = 8'h20;
   localparam logic [7:0] P_NP_READ   = 8'h00;
   localparam logic [7:0] P_RAND_READ = 8'h04;
   localparam logic [7:0] P_PRI_WRITE = 8'h1E;
   localparam logic [7:0] P_NP_WRITE  = 8'h02;
   localparam logic [7:0] P_PRINT     = 8'h22;
   localparam logic [7:0] P_PRINT_RPL = 8'h92;

   // Modbus functions
   localparam logic [7:0] F_RD_COIL   = 8'h01;
   localparam logic [7:0] F_RD_INPUT  = 8'h02;
   localparam logic [7:0] F_RD_HOLD   = 8'h03;
   localparam logic [7:0] F_RD_INREG  = 8'h04;
   localparam logic [7:0] F_WR_COIL   = 8'h05;
   localparam logic [7:0] F_WR_REG    = 8'h06;
   localparam logic [7:0] F_WR_COILS  = 8'h0F;
   localparam logic [7:0] F_WR_REGS   = 8'h10;
   localparam logic [7:0] F_ENCAP     = 8'h11;
   localparam logic [7:0] F_MASK_WR   = 8'h16;
   localparam logic [7:0] F_RAND_RD   = 8'h64;

   // Encapsulation markers and coil/input read status tags
   localparam logic [7:0]  ENC_QUERY  = 8'h01;
   localparam logic [7:0]  ENC_REPLY  = 8'h02;
   localparam logic [15:0] ENC_STATUS = 16'hBAD5;
   localparam logic [7:0]  COIL_TAG   = 8'h03;
   localparam logic [7:0]  INPUT_TAG  = 8'h05;

   // Peer register window
   localparam logic [15:0] P_ADDR_MIN = 16'h0001;
   localparam logic [15:0] P_ADDR_MAX = 16'h2000;
   localparam logic [15:0] FULL_MASK  = 16'hFFFF;

   // Retry state machine
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } retry_state_type;

endpackage

// >>> msg_translator.sv
/*
 * Peer-to-Modbus and Modbus-to-peer header translator with encapsulation,
 * configurable master opcode and register offset, and a request retry
 * timer. Header fields arrive already parsed from framing logic on the same
 * clock; each request is a one-cycle strobe, each answer a one-cycle pulse
 * in the next cycle.
 */
// Added by the designer: strobed register access and the register addresses.
// Operation
// RULE1 - Peer reads become read holding registers
// RULE2 - Priority or full-mask write becomes function 16
// RULE3 - Single partial contiguous mask becomes function 22
// RULE4 - Untranslatable peer command wrapped, function 17, 0x01
// RULE5 - Encapsulated peer replies carry parameter 0x02
// RULE6 - Function 17 with parameters is encapsulated
// RULE7 - Functions 1,2 become priority read, coded status
// RULE8 - Functions 3,4 non-priority read, transaction 3/4
// RULE9 - Single coil: write, transaction 5, one bit
// RULE10 - Single register: write, transaction 6
// RULE11 - Multiple coils in one register, transaction 0x0F
// RULE12 - Function 16: write, transaction 0x10
// RULE13 - Function 22: write, transaction 0x10, mask
// RULE14 - Function 100 becomes random read 0x04
// RULE15 - Other Modbus requests wrapped in print, 0xBAD5
// RULE16 - Encapsulated Modbus replies use print reply 0x92
// RULE17 - Address byte after status: zero sent, ignored
// RULE18 - Strict type translates only 3,16,22,100
// RULE19 - Host mode uses chosen opcodes and offset
// RULE20 - 16-bit offset, only outgoing host translations
// RULE21 - Peer addresses valid only 1 to 8192
// RULE22 - Gate/host ports answer peer wraps with error
// RULE23 - Register address is peer address plus offset
// RULE24 - Coil start is ((addr+offset-1)*16)+1
// RULE25 - Retransmit on timeout, at most two retries
// RULE26 - Unfitting peer writes go to encapsulation
`timescale 1ns/1ps

module msg_translator
   import xlate_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        p_req,
   input  wire logic [7:0]  p_op,
   input  wire logic [15:0] p_addr,
   input  wire logic [7:0]  p_count,
   input  wire logic [15:0] p_mask,
   input  wire logic        p_is_reply,
   output logic             m_valid,
   output logic      [7:0]  m_func,
   output logic      [15:0] m_addr,
   output logic      [15:0] m_mask,
   output logic             m_encap,
   output logic      [7:0]  m_param,
   input  wire logic        mb_req,
   input  wire logic [7:0]  mb_func,
   input  wire logic [15:0] mb_addr,
   input  wire logic [15:0] mb_count,
   input  wire logic [15:0] mb_and_mask,
   input  wire logic        mb_has_param,
   input  wire logic        mb_is_reply,
   output logic             s_valid,
   output logic      [7:0]  s_op,
   output logic      [15:0] s_addr,
   output logic      [15:0] s_status,
   output logic      [15:0] s_mask,
   output logic             s_encap,
   output logic      [7:0]  s_addr_byte,
   output logic             s_unwrap,
   output logic             enc_err,
   input  wire logic        tx_start,
   input  wire logic        reply_ok,
   output logic             retx,
   output logic             give_up
);

   // Mask is one run of ones
   function automatic logic contig(input logic [15:0] m);
      logic [15:0] low;
      low = m & (~m + 16'h0001);
      return (m != 16'h0000) && (((m + low) & m) == 16'h0000);
   endfunction

   // Run of n ones starting at bit s
   function automatic logic [15:0] span(input logic [4:0] n,
                                        input logic [3:0] s);
      logic [16:0] ones;
      ones = (17'h00001 << n) - 17'h00001;
      return ones[15:0] << s;
   endfunction

   // Register file
   logic [1:0]  mode_r;
   logic        strict_r;
   logic [15:0] bias_r;
   logic [7:0]  rd_op_r;
   logic [7:0]  wr_op_r;
   logic [15:0] retry_r;
   logic        gaveup_r;
   logic [1:0]  tries_r;
   retry_state_type state_r;

   wire wr_ctrl  = reg_wr && (reg_addr == OFS_CTRL);
   wire wr_bias  = reg_wr && (reg_addr == OFS_BIAS);
   wire wr_opc   = reg_wr && (reg_addr == OFS_OPCODE);
   wire wr_retry = reg_wr && (reg_addr == OFS_RETRY);
   wire wr_stat  = reg_wr && (reg_addr == OFS_STATUS);

   // Unmapped offsets read as zero
   logic [31:0] rdata_nxt;
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (reg_addr)
         OFS_CTRL:   rdata_nxt = {29'h0, strict_r, mode_r};
         OFS_BIAS:   rdata_nxt = {16'h0000, bias_r};
         OFS_OPCODE: rdata_nxt = {16'h0000, wr_op_r, rd_op_r};
         OFS_RETRY:  rdata_nxt = {16'h0000, retry_r};
         OFS_STATUS: rdata_nxt = {28'h0, gaveup_r,
                                  state_r == ST_WAIT, tries_r};
         default:    rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Configuration writes; the offset takes any 16-bit value
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mode_r   <= RST_MODE;
         strict_r <= 1'b0;
         bias_r   <= RST_BIAS;
         rd_op_r  <= RST_RD_OP;
         wr_op_r  <= RST_WR_OP;
         retry_r  <= RST_RETRY;
         reg_rdata <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            mode_r   <= reg_wdata[CTRL_MODE_LSB +: 2];
            strict_r <= reg_wdata[CTRL_STRICT];
         end
         if (wr_bias) bias_r <= reg_wdata[15:0];      // [RULE20]
         if (wr_opc) begin
            rd_op_r <= reg_wdata[OPC_RD_LSB +: 8];
            wr_op_r <= reg_wdata[OPC_WR_LSB +: 8];
         end
         if (wr_retry) retry_r <= reg_wdata[15:0];
         reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
      end
   end

   // Peer side decode
   wire host    = (mode_r == MODE_HOST);
   wire is_read = (p_op == P_PRI_READ) || (p_op == P_NP_READ);
   wire is_pwr  = (p_op == P_PRI_WRITE);
   wire is_npw  = (p_op == P_NP_WRITE);
   wire full_mk = (p_mask == FULL_MASK);
   wire addr_ok = (p_addr >= P_ADDR_MIN) && (p_addr <= P_ADDR_MAX); // [RULE21]
   wire fx_wm   = is_pwr || (is_npw && full_mk);                    // [RULE2]
   wire fx_mw   = is_npw && (p_count == 8'h01) && !full_mk
                  && contig(p_mask);                                 // [RULE3]
   wire h_ok    = is_read || is_pwr || (is_npw && full_mk);
   // Partial writes never half-translate: all but a single contiguous one (non-host) fall to the wrapper
   wire p_xl    = addr_ok && (host ? h_ok :
                              (is_read || fx_wm || fx_mw));   // [RULE26]

   // Offset only outgoing in host mode
   wire [15:0] r_addr = host ? p_addr + bias_r : p_addr; // [RULE20] [RULE23]
   wire [15:0] c_addr = {r_addr[11:0] - 12'h001, 4'h0} + 16'h0001; // [RULE24]
   wire [7:0]  h_func = is_read ? rd_op_r : wr_op_r;          // [RULE19]
   wire h_coil = (h_func == F_RD_COIL) || (h_func == F_RD_INPUT) ||
                 (h_func == F_WR_COIL) || (h_func == F_WR_COILS);
   wire [7:0]  fx_func = is_read ? F_RD_HOLD :                // [RULE1]
                         fx_mw   ? F_MASK_WR : F_WR_REGS;     // [RULE2] [RULE3]

   logic [7:0]  m_func_nxt;
   logic [15:0] m_addr_nxt;
   assign m_func_nxt = !p_xl ? F_ENCAP : host ? h_func : fx_func; // [RULE4]
   assign m_addr_nxt = (host && h_coil) ? c_addr : r_addr;

   // Peer to Modbus answer register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         m_valid <= 1'b0;
         m_func  <= 8'h00;
         m_addr  <= 16'h0000;
         m_mask  <= 16'h0000;
         m_encap <= 1'b0;
         m_param <= 8'h00;
      end else begin
         m_valid <= p_req;
         if (p_req) begin
            m_func  <= m_func_nxt;
            m_addr  <= m_addr_nxt;
            m_mask  <= p_mask;
            m_encap <= !p_xl;
            m_param <= !p_xl ? (p_is_reply ? ENC_REPLY          // [RULE5]
                                           : ENC_QUERY) : 8'h00; // [RULE4]
         end
      end
   end

   // Modbus side decode; slave translations use no offset
   wire [15:0] b0      = mb_addr - 16'h0001;
   wire [3:0]  bitpos  = b0[3:0];
   wire [15:0] c_reg   = {4'h0, b0[15:4]} + 16'h0001;
   wire        is_coil = (mb_func == F_RD_COIL) || (mb_func == F_RD_INPUT) ||
                         (mb_func == F_WR_COIL) || (mb_func == F_WR_COILS);
   wire [15:0] pa      = is_coil ? c_reg : mb_addr;           // [RULE20]
   wire        pa_ok   = (pa >= P_ADDR_MIN) && (pa <= P_ADDR_MAX); // [RULE21]
   wire        fits15  = (mb_count != 16'h0000) && (mb_count < 16'h0010) &&
                         ({12'h000, bitpos} + mb_count <= 16'h0010); // [RULE11]
   wire        std_ok  = (mb_func == F_RD_HOLD) || (mb_func == F_WR_REGS) ||
                         (mb_func == F_MASK_WR) || (mb_func == F_RAND_RD);
   wire        other_ok = std_ok || (mb_func == F_RD_COIL) ||
                         (mb_func == F_RD_INPUT) || (mb_func == F_RD_INREG) ||
                         (mb_func == F_WR_COIL) || (mb_func == F_WR_REG) ||
                         ((mb_func == F_WR_COILS) && fits15);
   wire        mb_xl   = pa_ok && (strict_r ? std_ok : other_ok); // [RULE18]
   wire        wrapped = (mb_func == F_ENCAP) && mb_has_param;    // [RULE6]
   wire        err_mode = (mode_r == MODE_GATE) || host;          // [RULE22]

   // Opcode, status field and mask per function
   logic [7:0]  s_op_nxt;
   logic [15:0] s_stat_nxt;
   logic [15:0] s_mask_nxt;
   always_comb begin
      s_op_nxt   = mb_is_reply ? P_PRINT_RPL : P_PRINT;  // [RULE15] [RULE16]
      s_stat_nxt = ENC_STATUS;                          // [RULE15]
      s_mask_nxt = FULL_MASK;
      if (mb_xl) begin
         s_stat_nxt = {8'h00, mb_func};          // [RULE8] [RULE10] [RULE12]
         unique case (mb_func)
            F_RD_COIL, F_RD_INPUT: begin                // [RULE7]
               s_op_nxt   = P_PRI_READ;
               s_stat_nxt = {bitpos, mb_count[3:0],
                   (mb_func == F_RD_COIL) ? COIL_TAG : INPUT_TAG};
            end
            F_RD_HOLD, F_RD_INREG: s_op_nxt = P_NP_READ;  // [RULE8]
            F_WR_COIL: begin                              // [RULE9]
               s_op_nxt   = P_NP_WRITE;
               s_mask_nxt = 16'h0001 << bitpos;
            end
            F_WR_COILS: begin                             // [RULE11]
               s_op_nxt   = P_NP_WRITE;
               s_mask_nxt = span(mb_count[4:0], bitpos);
            end
            F_MASK_WR: begin                              // [RULE13]
               s_op_nxt   = P_NP_WRITE;
               s_stat_nxt = {8'h00, F_WR_REGS};
               s_mask_nxt = ~mb_and_mask;
            end
            F_RAND_RD: s_op_nxt = P_RAND_READ;            // [RULE14]
            default:   s_op_nxt = P_NP_WRITE;             // [RULE10] [RULE12]
         endcase
      end
   end

   // Modbus to peer answer register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_valid     <= 1'b0;
         s_op        <= 8'h00;
         s_addr      <= 16'h0000;
         s_status    <= 16'h0000;
         s_mask      <= 16'h0000;
         s_encap     <= 1'b0;
         s_addr_byte <= 8'h00;
         s_unwrap    <= 1'b0;
         enc_err     <= 1'b0;
      end else begin
         s_valid  <= mb_req && !wrapped;
         s_unwrap <= mb_req && wrapped && !err_mode;       // [RULE6]
         enc_err  <= mb_req && wrapped && err_mode;        // [RULE22]
         if (mb_req) begin
            s_op        <= s_op_nxt;
            s_addr      <= pa;
            s_status    <= s_stat_nxt;
            s_mask      <= s_mask_nxt;
            s_encap     <= !mb_xl;
            s_addr_byte <= 8'h00;           // [RULE17] never carried over
         end
      end
   end

   // Retry timer: unit prescaler and timeout count
   logic [7:0]  pre_r;
   logic [15:0] wait_r;
   wire unit_tick = (pre_r == 8'(RETRY_UNIT_CYC - 1));
   wire expired   = unit_tick && (wait_r >= retry_r);

   // A reply in the expiry cycle wins; no needless resend
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r  <= ST_IDLE;
         tries_r  <= 2'h0;
         pre_r    <= 8'h00;
         wait_r   <= 16'h0000;
         retx     <= 1'b0;
         give_up  <= 1'b0;
         gaveup_r <= 1'b0;
      end else begin
         retx    <= 1'b0;
         give_up <= 1'b0;
         pre_r   <= (state_r == ST_IDLE || unit_tick) ? 8'h00 : pre_r + 8'h01;
         if (unit_tick) wait_r <= wait_r + 16'h0001;
         unique case (state_r)
            ST_IDLE: if (tx_start) begin
               state_r <= ST_WAIT;
               tries_r <= 2'h0;
               wait_r  <= 16'h0000;
            end
            ST_WAIT: if (reply_ok) begin
               state_r <= ST_IDLE;
            end else if (expired) begin
               wait_r <= 16'h0000;
               if (tries_r < MAX_RETRIES) begin                 // [RULE25]
                  tries_r <= tries_r + 2'h1;
                  retx    <= 1'b1;
               end else begin
                  state_r <= ST_IDLE;
                  give_up <= 1'b1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
         // Sticky flag: hardware set wins over write-one clear
         if (state_r == ST_WAIT && !reply_ok && expired &&
             tries_r == MAX_RETRIES)
            gaveup_r <= 1'b1;
         else if (wr_stat && reg_wdata[STAT_GAVEUP])
            gaveup_r <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   rd_xlate_a: assert property (                                // [RULE1]
      p_req && !host && addr_ok && is_read |=> m_valid && m_func == F_RD_HOLD)
      else $error("peer read not sent as function 3");
   wr_xlate_a: assert property (                                // [RULE2]
      p_req && !host && addr_ok && fx_wm |=> m_func == F_WR_REGS && !m_encap)
      else $error("full write not sent as function 16");
   encap_a: assert property (                                   // [RULE4]
      p_req && p_op == P_PRINT && !p_is_reply
      |=> m_func == F_ENCAP && m_param == ENC_QUERY && m_encap)
      else $error("print not wrapped in function 17");
   coil_rd_a: assert property (                                 // [RULE7]
      mb_req && mb_xl && mb_func == F_RD_COIL
      |=> s_op == P_PRI_READ && s_status[7:0] == COIL_TAG
          && s_status[15:12] == $past(bitpos))
      else $error("coil read status code wrong");
   mb_wrap_a: assert property (                                 // [RULE15]
      mb_req && !mb_is_reply && !wrapped && !mb_xl
      |=> s_valid && s_op == P_PRINT && s_status == ENC_STATUS)
      else $error("untranslated request not wrapped in print");
   strict_a: assert property (                                  // [RULE18]
      mb_req && strict_r && mb_func == F_RD_INREG |=> s_encap)
      else $error("strict type translated function 4");
   bias_a: assert property (                                    // [RULE23]
      p_req && host && p_xl && !h_coil
      |=> m_addr == $past(p_addr) + $past(bias_r))
      else $error("host register address lacks offset");
   enc_err_a: assert property (                                 // [RULE22]
      mb_req && wrapped && err_mode |=> enc_err && !s_unwrap && !s_valid)
      else $error("wrapped peer message forwarded");

   sequence s_third_timeout;
      state_r == ST_WAIT && expired && !reply_ok && tries_r == MAX_RETRIES;
   endsequence
   retry_cap_a: assert property (                               // [RULE25]
      s_third_timeout |=> give_up && !retx && state_r == ST_IDLE)
      else $error("retry limit not enforced");

endmodule // msg_translator

// >>> mb_slave_model.sv
/*
 * Modbus slave stand-in for the translator bench: transmits each translated
 * request and answers it after a short delay, or stays silent when told to.
 * Assumes the one-cycle m_valid pulse of the translator.
 */
`timescale 1ns/1ps

module mb_slave_model (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic m_valid,
   input  wire logic answer,
   output logic      tx_start,
   output logic      reply_ok
);
   logic [5:0] wait_r;

   // Send on every request; a newer request restarts the reply delay
   always_ff @(posedge mclk) begin
      tx_start <= rst_n & m_valid;
      reply_ok <= 1'b0;
      if (!rst_n) begin
         wait_r <= 6'h00;
      end else if (m_valid) begin
         wait_r <= answer ? 6'h14 : 6'h00;
      end else if (wait_r != 6'h00) begin
         wait_r   <= wait_r - 6'h01;
         reply_ok <= (wait_r == 6'h01); // Well inside timeout
      end
   end
endmodule // mb_slave_model

// >>> msg_translator_tb.sv
/*
 * Self-checking bench for msg_translator: register port tasks, peer and
 * Modbus request tasks with expected fields, and a retry run.
 * Assumes mb_slave_model drives tx_start and reply_ok.
 */
`timescale 1ns/1ps

module msg_translator_tb;
   import xlate_pkg::*;
   logic        mclk, rst_n, reg_wr, reg_rd, p_req, p_is_reply, mb_req;
   logic        mb_has_param, mb_is_reply, m_valid, m_encap, s_valid;
   logic        s_encap, s_unwrap, enc_err, tx_start, reply_ok, retx;
   logic        give_up, answer;
   logic [7:0]  reg_addr, p_op, p_count, m_func, m_param, mb_func, s_op;
   logic [7:0]  s_addr_byte;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] p_addr, p_mask, m_addr, m_mask, mb_addr, mb_count, s_addr;
   logic [15:0] mb_and_mask, s_status, s_mask;
   int          fail_count = 0, num_checks = 0, cycles = 0, n_retx, n_gu;

   msg_translator uut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .p_req, .p_op, .p_addr, .p_count, .p_mask,
      .p_is_reply, .m_valid, .m_func, .m_addr, .m_mask, .m_encap, .m_param,
      .mb_req, .mb_func, .mb_addr, .mb_count, .mb_and_mask, .mb_has_param,
      .mb_is_reply, .s_valid, .s_op, .s_addr, .s_status, .s_mask, .s_encap,
      .s_addr_byte, .s_unwrap, .enc_err, .tx_start, .reply_ok, .retx,
      .give_up);
   mb_slave_model slave (.mclk, .rst_n, .m_valid, .answer, .tx_start,
      .reply_ok);

   // Clock, 8 ns period
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Hang guard, well above the roughly 1900 cycles the run needs
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   // One-cycle strobes; read data stand only in the cycle after
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] mk = '1);
      @(posedge mclk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata & mk);
   endtask

   // Peer request; the answer fields are checked in the m_valid cycle
   task automatic pq(logic [7:0] op, logic [15:0] a, logic [7:0] c,
                     logic [15:0] mk, logic rp, logic [7:0] ef,
                     logic [15:0] ea);
      logic enc;
      enc = (ef == F_ENCAP);
      @(posedge mclk);
      {p_op, p_addr, p_count, p_mask, p_is_reply, p_req} <=
         {op, a, c, mk, rp, 1'b1};
      @(posedge mclk);
      p_req <= 1'b0;
      #1 chk("m_out", {1'b1, ef, enc, enc ? (rp ? ENC_REPLY : ENC_QUERY) :
         8'h00}, {m_valid, m_func, m_encap, m_param});
      if (!enc) chk("m_addr", ea, m_addr);
      chk("m_mask", mk, m_mask);
   endtask

   // Modbus request; with parameters eop holds valid/unwrap/error
   task automatic mq(logic [7:0] f, logic [15:0] a, logic [15:0] c,
                     logic [15:0] am, logic hp, logic rp, logic [7:0] eop,
                     logic [15:0] est, logic [15:0] ea);
      logic enc;
      enc = (est == ENC_STATUS);
      @(posedge mclk);
      {mb_func, mb_addr, mb_count, mb_and_mask, mb_has_param, mb_is_reply,
         mb_req} <= {f, a, c, am, hp, rp, 1'b1};
      @(posedge mclk);
      mb_req <= 1'b0;
      #1;
      if (hp) chk("pulses", eop, {s_valid, s_unwrap, enc_err});
      else chk("s_out", {1'b1, enc, 8'h00, eop, est},
         {s_valid, s_encap, s_addr_byte, s_op, s_status});
      if (!hp && !enc) chk("s_addr", ea, s_addr);
   endtask

   task automatic count_pulses(int n);
      {n_retx, n_gu} = '0;
      repeat (n) begin
         @(posedge mclk);
         #1 n_retx += int'(retx === 1'b1);
         n_gu += int'(give_up === 1'b1);
      end
   endtask

   // Main sequence
   initial begin
      {reg_wr, reg_rd, p_req, mb_req, p_is_reply, mb_has_param} = '0;
      {mb_is_reply, reg_addr, reg_wdata, p_op, p_addr, p_count} = '0;
      {p_mask, mb_func, mb_addr, mb_count, mb_and_mask, rst_n} = '0;
      answer = 1'b1;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      rd(OFS_OPCODE, 32'h0000_1003);
      rd(OFS_RETRY, 32'h0000_03E8);
      rd(8'h20, 32'h0);
      pq(8'h20, 16'h0005, 8'h01, 16'hFFFF, 1'b0, F_RD_HOLD, 16'h0005);
      pq(8'h1E, 16'h0005, 8'h02, 16'hFFFF, 1'b0, F_WR_REGS, 16'h0005);
      pq(8'h02, 16'h0005, 8'h02, 16'hFFFF, 1'b0, F_WR_REGS, 16'h0005);
      pq(8'h02, 16'h0005, 8'h01, 16'h00F0, 1'b0, F_MASK_WR, 16'h0005);
      pq(8'h02, 16'h0005, 8'h01, 16'h0F0F, 1'b0, F_ENCAP, 16'h0);
      pq(8'h22, 16'h0005, 8'h01, 16'hFFFF, 1'b0, F_ENCAP, 16'h0);
      pq(8'h22, 16'h0005, 8'h01, 16'hFFFF, 1'b1, F_ENCAP, 16'h0);
      pq(8'h00, 16'h2001, 8'h01, 16'hFFFF, 1'b0, F_ENCAP, 16'h0);
      pq(8'h00, 16'h2000, 8'h01, 16'hFFFF, 1'b0, F_RD_HOLD, 16'h2000);
      mq(8'h01, 16'd18, 16'd3, 16'h0, 0, 0, 8'h20, 16'h1303, 16'h2);
      mq(8'h02, 16'd18, 16'd3, 16'h0, 0, 0, 8'h20, 16'h1305, 16'h2);
      mq(8'h03, 16'd7, 16'd2, 16'h0, 0, 0, 8'h00, 16'h0003, 16'd7);
      mq(8'h06, 16'd7, 16'd1, 16'h0, 0, 0, 8'h02, 16'h0006, 16'd7);
      chk("s_mask", 16'hFFFF, s_mask);
      mq(8'h05, 16'd20, 16'd1, 16'h0, 0, 0, 8'h02, 16'h0005, 16'h2);
      chk("s_mask", 16'h0008, s_mask);
      mq(8'h0F, 16'd17, 16'd4, 16'h0, 0, 0, 8'h02, 16'h000F, 16'h2);
      chk("s_mask", 16'h000F, s_mask);
      mq(8'h0F, 16'd17, 16'd16, 16'h0, 0, 0, 8'h22, ENC_STATUS, 0);
      mq(8'h16, 16'd7, 16'd1, 16'hFF00, 0, 0, 8'h02, 16'h0010, 16'd7);
      chk("s_mask", 16'h00FF, s_mask);
      mq(8'h64, 16'd7, 16'd2, 16'h0, 0, 0, 8'h04, 16'h0064, 16'd7);
      mq(8'h08, 16'd7, 16'd1, 16'h0, 0, 0, 8'h22, ENC_STATUS, 0);
      mq(8'h08, 16'd7, 16'd1, 16'h0, 0, 1, 8'h92, ENC_STATUS, 0);
      mq(8'h11, 16'd7, 16'd1, 16'h0, 1, 0, 8'h01, 16'h0, 0);
      mq(8'h11, 16'd7, 16'd1, 16'h0, 0, 0, 8'h22, ENC_STATUS, 0);
      wr(OFS_CTRL, 32'h4);
      mq(8'h04, 16'd7, 16'd2, 16'h0, 0, 0, 8'h22, ENC_STATUS, 0);
      mq(8'h10, 16'd7, 16'd2, 16'h0, 0, 0, 8'h02, 16'h0010, 16'd7);
      wr(OFS_CTRL, {30'h0, MODE_ASCII});
      mq(8'h11, 16'd7, 16'd1, 16'h0, 1, 0, 8'h02, 16'h0, 0);
      wr(OFS_CTRL, {30'h0, MODE_HOST});
      wr(OFS_BIAS, 32'h0FA0);
      wr(OFS_OPCODE, 32'h1004);
      pq(8'h00, 16'h1437, 8'h01, 16'hFFFF, 1'b0, 8'h04, 16'h23D7);
      pq(8'h1E, 16'h1437, 8'h02, 16'hFFFF, 1'b0, 8'h10, 16'h23D7);
      wr(OFS_OPCODE, 32'h1001);
      pq(8'h20, 16'h0002, 8'h01, 16'hFFFF, 1'b0, 8'h01, 16'hFA11);
      mq(8'h11, 16'd7, 16'd1, 16'h0, 1, 0, 8'h01, 16'h0, 0);
      wr(OFS_CTRL, {30'h0, MODE_SLAVE});
      mq(8'h03, 16'd7, 16'd2, 16'h0, 0, 0, 8'h00, 16'h0003, 16'd7);
      // Silent slave: two resends, then one give-up
      wr(OFS_RETRY, 32'h1);
      answer <= 1'b0;
      pq(8'h20, 16'h0005, 8'h01, 16'hFFFF, 1'b0, 8'h03, 16'h0005);
      count_pulses(1200);
      chk("retx", 2, n_retx);
      chk("give_up", 1, n_gu);
      rd(OFS_STATUS, 32'h8, 32'h8);
      wr(OFS_STATUS, 32'h8);
      rd(OFS_STATUS, 32'h0, 32'h8);
      answer <= 1'b1;
      pq(8'h20, 16'h0005, 8'h01, 16'hFFFF, 1'b0, 8'h03, 16'h0005);
      count_pulses(600);
      chk("retx", 0, n_retx + n_gu);
      finish_test();
   end
endmodule // msg_translator_tb
